/* File: rtl/ddl_top.sv */
// update latency pipeline: commit/profile sampling to output words
`default_nettype none

module ddl_top
  import ddl_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   sync_clk_i,
  input  wire logic                   commit_i,
  input  wire logic [`DDL_PROF_W-1:0] profile_i,
  input  wire ddl_mode_t              mode_i,
  input  wire logic                   matched_i,
  input  wire ddl_words_t             commit_words_i,
  input  wire ddl_words_t             prof_words_i,
  input  wire ddl_words_t             rise_words_i,
  input  wire ddl_words_t             fall_words_i,
  output logic                        update_taken_o,
  output logic                        profile_taken_o,
  output logic      [`DDL_PROF_W-1:0] profile_sel_o,
  output ddl_words_t                  out_words_o
);

  localparam int AW = `DDL_AW;
  localparam int SW = `DDL_PROF_W + 2;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and sampling edge

  logic [SW-1:0]          s1_r;
  logic [SW-1:0]          s2_r;
  logic                   sclk_d_r;
  logic [`DDL_PROF_W-1:0] prof_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r     <= '0;
      s2_r     <= '0;
      sclk_d_r <= 1'b0;
      prof_r   <= `DDL_PROF_RST;
    end else begin
      s1_r     <= {sync_clk_i, commit_i, profile_i};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[SW-1];
      if (profile_taken_o) begin
        prof_r <= s2_r[`DDL_PROF_W-1:0];
      end
    end
  end

  // all pins share one synchroniser delay, so their alignment holds
  wire                   sync_rise_w = s2_r[SW-1] & ~sclk_d_r;
  wire                   commit_s_w  = s2_r[SW-2];
  wire [`DDL_PROF_W-1:0] prof_s_w    = s2_r[`DDL_PROF_W-1:0];
  wire                   single_w    = (mode_i == DDL_MODE_SINGLE);
  wire                   sweep_w     = (mode_i == DDL_MODE_SWEEP);

  // single tone counts from commit, the others from a profile change
  assign update_taken_o  = sync_rise_w & commit_s_w & single_w;
  assign profile_taken_o = sync_rise_w & ~single_w &
                           (prof_s_w != prof_r);
  assign profile_sel_o   = prof_r;

  wire        event_w = update_taken_o | profile_taken_o;
  // sweep direction follows the lowest profile pin
  wire ddl_words_t src_w =
    single_w            ? commit_words_i :
    !sweep_w            ? prof_words_i   :
    prof_s_w[0]         ? rise_words_i   : fall_words_i;

  ////////////////////////////////////////////////////////////////////////////
  // delay memories, one per channel so each can have its own latency

  logic [AW-1:0] wp_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
    end else begin
      wp_r <= wp_r + 1'b1;
    end
  end

  wire [AW-1:0] frq_ra_w = wp_r - ddl_gap(mode_i, matched_i, DDL_CH_FRQ);
  wire [AW-1:0] phs_ra_w = wp_r - ddl_gap(mode_i, matched_i, DDL_CH_PHS);
  wire [AW-1:0] amp_ra_w = wp_r - ddl_gap(mode_i, matched_i, DDL_CH_AMP);

  logic [`DDL_FRQ_W-1:0] frq_rd;
  logic [`DDL_PHS_W-1:0] phs_rd;
  logic [`DDL_AMP_W-1:0] amp_rd;
  logic                  frq_vld;
  logic                  phs_vld;
  logic                  amp_vld;

  ddl_delay_mem #(.W(`DDL_FRQ_W), .AW(AW)) u_frq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_addr_i (wp_r),
    .wr_data_i (src_w.frq),
    .wr_vld_i  (event_w),
    .rd_addr_i (frq_ra_w),
    .rd_data_o (frq_rd),
    .rd_vld_o  (frq_vld)
  );

  ddl_delay_mem #(.W(`DDL_PHS_W), .AW(AW)) u_phs (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_addr_i (wp_r),
    .wr_data_i (src_w.phs),
    .wr_vld_i  (event_w),
    .rd_addr_i (phs_ra_w),
    .rd_data_o (phs_rd),
    .rd_vld_o  (phs_vld)
  );

  ddl_delay_mem #(.W(`DDL_AMP_W), .AW(AW)) u_amp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_addr_i (wp_r),
    .wr_data_i (src_w.amp),
    .wr_vld_i  (event_w),
    .rd_addr_i (amp_ra_w),
    .rd_data_o (amp_rd),
    .rd_vld_o  (amp_vld)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output stage: load words, or ramp by the delayed delta in sweep

  ddl_words_t out_r;
  ddl_words_t out_nxt;
  ddl_words_t step_r;
  ddl_words_t step_nxt;

  assign step_nxt.frq = frq_vld ? frq_rd : step_r.frq;
  assign step_nxt.phs = phs_vld ? phs_rd : step_r.phs;
  assign step_nxt.amp = amp_vld ? amp_rd : step_r.amp;

  // sweep wraps modulo the field width, as an accumulator does
  assign out_nxt.frq = sweep_w ? out_r.frq + step_nxt.frq
                               : (frq_vld ? frq_rd : out_r.frq);
  assign out_nxt.phs = sweep_w ? out_r.phs + step_nxt.phs
                               : (phs_vld ? phs_rd : out_r.phs);
  assign out_nxt.amp = sweep_w ? out_r.amp + step_nxt.amp
                               : (amp_vld ? amp_rd : out_r.amp);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r  <= '0;
      step_r <= '0;
    end else begin
      out_r  <= out_nxt;
      step_r <= step_nxt;
    end
  end

  assign out_words_o = out_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_frq_land(logic [`DDL_FRQ_W-1:0] v);
    (frq_vld && frq_rd == v) ##1 (out_r.frq == v);
  endsequence

  sequence s_phs_land(logic [`DDL_PHS_W-1:0] v);
    (phs_vld && phs_rd == v) ##1 (out_r.phs == v);
  endsequence

  sequence s_amp_land(logic [`DDL_AMP_W-1:0] v);
    (amp_vld && amp_rd == v) ##1 (out_r.amp == v);
  endsequence

  property p_st_match;
    logic [`DDL_AMP_W-1:0] v;
    (update_taken_o && matched_i, v = commit_words_i.amp)
      |-> ##28 s_amp_land(v);
  endproperty
  a_st_match: assert property (p_st_match)
    else $error("matched amplitude did not land at 29");

  property p_st_frq;
    logic [`DDL_FRQ_W-1:0] v;
    (update_taken_o && !matched_i, v = commit_words_i.frq)
      |-> ##28 s_frq_land(v);
  endproperty
  a_st_frq: assert property (p_st_frq)
    else $error("frequency word did not land at 29");

  property p_st_phs;
    logic [`DDL_PHS_W-1:0] v;
    (update_taken_o && !matched_i, v = commit_words_i.phs)
      |-> ##24 s_phs_land(v);
  endproperty
  a_st_phs: assert property (p_st_phs)
    else $error("phase word did not land at 25");

  property p_st_amp;
    logic [`DDL_AMP_W-1:0] v;
    (update_taken_o && !matched_i, v = commit_words_i.amp)
      |-> ##16 s_amp_land(v);
  endproperty
  a_st_amp: assert property (p_st_amp)
    else $error("amplitude word did not land at 17");

  property p_mod_frq;
    logic [`DDL_FRQ_W-1:0] v;
    (profile_taken_o && mode_i == DDL_MODE_MOD, v = prof_words_i.frq)
      |-> ##33 s_frq_land(v);
  endproperty
  a_mod_frq: assert property (p_mod_frq)
    else $error("modulation frequency did not land at 34");

  property p_swp_amp;
    logic [`DDL_AMP_W-1:0] v;
    (profile_taken_o && sweep_w, v = src_w.amp)
      |-> ##28 (amp_vld && amp_rd == v) ##1
          (out_r.amp == $past(out_r.amp) + v);
  endproperty
  a_swp_amp: assert property (p_swp_amp)
    else $error("sweep amplitude delta did not act at 29");

  property p_no_cause;
    (!sweep_w && !phs_vld) |=> $stable(out_r.phs);
  endproperty
  a_no_cause: assert property (p_no_cause)
    else $error("phase output moved without a delayed word");

  // ties the pulse to the sync pin itself, two flops upstream
  property p_sample_edge;
    (update_taken_o || profile_taken_o) |-> $past(sync_clk_i, 2);
  endproperty
  a_sample_edge: assert property (p_sample_edge)
    else $error("input taken away from a sync clock rise");

  property p_reset;
    rst_i |=> (out_r == '0 && prof_r == `DDL_PROF_RST);
  endproperty
  a_reset: assert property (disable iff (1'b0) p_reset)
    else $error("outputs not at default after reset");

endmodule

`default_nettype wire

/* File: pkg/ddl_params.svh */
// constants for the update latency pipeline
//
// Function
// - single tone, matched: all three words land 29 cycles after commit
// - single tone, unmatched: frequency word lands 29 cycles after commit
// - single tone, unmatched: phase word lands 25 cycles after commit
// - single tone, unmatched: amplitude word lands 17 cycles after commit
// - modulation: profile change lands after 34, 29, 21 cycles
// - sweep: delta words act after 41, 37, 29 cycles from profile change
// - latencies fixed; single tone from commit, others from profile change
// - hard reset returns every internal register to its default, except the delay memory data array and its read data
`ifndef DDL_PARAMS_SVH
`define DDL_PARAMS_SVH

`define DDL_FRQ_W         32
`define DDL_PHS_W         14
`define DDL_AMP_W         10
`define DDL_PROF_W        4
`define DDL_AW            6

// latencies in core clock cycles, counted from the sampling edge
`define DDL_LAT_ST_MATCH  6'h1d
`define DDL_LAT_ST_FRQ    6'h1d
`define DDL_LAT_ST_PHS    6'h19
`define DDL_LAT_ST_AMP    6'h11
`define DDL_LAT_MOD_FRQ   6'h22
`define DDL_LAT_MOD_PHS   6'h1d
`define DDL_LAT_MOD_AMP   6'h15
`define DDL_LAT_SWP_FRQ   6'h29
`define DDL_LAT_SWP_PHS   6'h25
`define DDL_LAT_SWP_AMP   6'h1d
// read register plus output register
`define DDL_RD_STAGES     6'h02

`define DDL_PROF_RST      4'h0
`define DDL_MODE_RST      2'h0

`endif

/* File: pkg/ddl_pkg.sv */
// types and latency decode for the update latency pipeline
`include "ddl_params.svh"
`default_nettype none

package ddl_pkg;

  typedef enum logic [1:0] {
    DDL_MODE_SINGLE = 2'b00,
    DDL_MODE_MOD    = 2'b01,
    DDL_MODE_SWEEP  = 2'b10
  } ddl_mode_t;

  typedef enum logic [1:0] {
    DDL_CH_FRQ = 2'b00,
    DDL_CH_PHS = 2'b01,
    DDL_CH_AMP = 2'b10
  } ddl_chan_t;

  typedef struct packed {
    logic [`DDL_FRQ_W-1:0] frq;
    logic [`DDL_PHS_W-1:0] phs;
    logic [`DDL_AMP_W-1:0] amp;
  } ddl_words_t;

  // total latency of one channel in the given mode
  function automatic logic [5:0] ddl_lat(input ddl_mode_t m,
                                         input logic      matched,
                                         input ddl_chan_t ch);
    logic [5:0] l;
    l = `DDL_LAT_ST_FRQ;
    case (m)
      DDL_MODE_MOD: begin
        l = (ch == DDL_CH_FRQ) ? `DDL_LAT_MOD_FRQ :
            (ch == DDL_CH_PHS) ? `DDL_LAT_MOD_PHS : `DDL_LAT_MOD_AMP;
      end
      DDL_MODE_SWEEP: begin
        l = (ch == DDL_CH_FRQ) ? `DDL_LAT_SWP_FRQ :
            (ch == DDL_CH_PHS) ? `DDL_LAT_SWP_PHS : `DDL_LAT_SWP_AMP;
      end
      default: begin
        if (matched) begin
          l = `DDL_LAT_ST_MATCH;
        end else begin
          l = (ch == DDL_CH_FRQ) ? `DDL_LAT_ST_FRQ :
              (ch == DDL_CH_PHS) ? `DDL_LAT_ST_PHS : `DDL_LAT_ST_AMP;
        end
      end
    endcase
    return l;
  endfunction

  // read distance behind the write pointer
  function automatic logic [`DDL_AW-1:0] ddl_gap(input ddl_mode_t m,
                                                 input logic      matched,
                                                 input ddl_chan_t ch);
    logic [5:0] g;
    g = ddl_lat(m, matched, ch) - `DDL_RD_STAGES;
    return g[`DDL_AW-1:0];
  endfunction

endpackage

`default_nettype wire

/* File: rtl/ddl_delay_mem.sv */
// circular delay memory with registered read and reset-cleared valid bits
`default_nettype none

module ddl_delay_mem #(
  parameter int W  = 8,
  parameter int AW = 6
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i,
  input  wire logic          wr_vld_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [W-1:0]  rd_data_o,
  output logic               rd_vld_o
);

  logic [W-1:0]     mem_r [2**AW];
  logic [2**AW-1:0] vld_r;

  // data array carries no reset; stale words are masked by the valid bits
  always_ff @(posedge clk_i) begin
    mem_r[wr_addr_i] <= wr_data_i;
    rd_data_o        <= mem_r[rd_addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vld_r    <= '0;
      rd_vld_o <= 1'b0;
    end else begin
      vld_r[wr_addr_i] <= wr_vld_i;
      rd_vld_o         <= vld_r[rd_addr_i];
    end
  end

endmodule

`default_nettype wire

/* File: verif/ddl_ctrl_model.sv */
// controller model: sync clock, commit strobe and profile pins
`include "ddl_params.svh"
`default_nettype none

module ddl_ctrl_model (
  input  wire logic                   clk_i,
  output logic                        sync_clk_o,
  output logic                        commit_o,
  output logic      [`DDL_PROF_W-1:0] profile_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0]             div_r;
  logic                   prev_r;
  logic                   go_c;
  logic                   go_p;
  logic [`DDL_PROF_W-1:0] pend_p;
  logic                   fell;

  assign fell = prev_r && !sync_clk_o;

  initial begin
    sync_clk_o = 1'b0;
    commit_o   = 1'b0;
    profile_o  = '0;
    div_r      = 2'h0;
    prev_r     = 1'b0;
    go_c       = 1'b0;
    go_p       = 1'b0;
    pend_p     = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // 4 core cycles high, 4 low: 2-flop sampler must see each phase;
  // 31.25 mhz, far from the avoided oscillator band
  always @(negedge clk_i) begin
    div_r  <= div_r + 2'h1;
    prev_r <= sync_clk_o;
    if (div_r == 2'h3) begin
      sync_clk_o <= ~sync_clk_o;
    end
    // pins move just after a fall: full setup before the rise
    if (go_c && fell) begin
      commit_o <= 1'b1;
      go_c     <= 1'b0;
    end
    // released one whole sync period later
    if (commit_o && fell) begin
      commit_o <= 1'b0;
    end
    if (go_p && fell) begin
      profile_o <= pend_p;
      go_p      <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic strobe();
    @(posedge clk_i);
    go_c = 1'b1;
    while (go_c) @(posedge clk_i);
  endtask

  task automatic set_profile(input logic [`DDL_PROF_W-1:0] p);
    @(posedge clk_i);
    pend_p = p;
    go_p   = 1'b1;
    while (go_p) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

/* File: verif/test_dds_update_latency_pipeline.sv */
// self-checking bench for the update latency pipeline
`include "ddl_params.svh"
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module test_dds_update_latency_pipeline
  import ddl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam ddl_words_t WD_A  = {32'h1234_5678, 14'h0abc, 10'h155};
  localparam ddl_words_t WD_B  = {32'h0bad_f00d, 14'h2345, 10'h2aa};
  localparam ddl_words_t WD_C  = {32'h7654_3210, 14'h1111, 10'h0f0};
  localparam ddl_words_t DL_UP = {32'h0000_1001, 14'h0011, 10'h003};
  localparam ddl_words_t DL_DN = {32'hffff_ff00, 14'h3ff0, 10'h3fe};

  logic                   clk_i;
  logic                   rst_i;
  logic                   sync_clk;
  logic                   commit;
  logic [`DDL_PROF_W-1:0] profile;
  ddl_mode_t              mode;
  logic                   matched;
  ddl_words_t             cw;
  ddl_words_t             pw;
  ddl_words_t             rw;
  ddl_words_t             fw;
  logic                   upd;
  logic                   prf;
  logic [`DDL_PROF_W-1:0] sel;
  ddl_words_t             outw;
  int                     errors;
  int                     checks;

  ddl_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sync_clk_i(sync_clk),
    .commit_i(commit), .profile_i(profile), .mode_i(mode),
    .matched_i(matched), .commit_words_i(cw), .prof_words_i(pw),
    .rise_words_i(rw), .fall_words_i(fw), .update_taken_o(upd),
    .profile_taken_o(prf), .profile_sel_o(sel), .out_words_o(outw)
  );

  ddl_ctrl_model u_ctrl (
    .clk_i(clk_i), .sync_clk_o(sync_clk), .commit_o(commit),
    .profile_o(profile)
  );

  always #2 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input int n);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (n) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("out_words", 56'h0, outw)
    `CHK("profile_sel", 4'h0, sel)
    repeat (4) @(negedge clk_i);
  endtask

  task automatic wait_evt(input bit prf_ev);
    int   i;
    logic p;
    p = 1'b0;
    for (i = 0; i < 40 && p !== 1'b1; i++) begin
      @(negedge clk_i);
      p = prf_ev ? prf : upd;
    end
    `CHK("event", 1'b1, p)
  endtask

  task automatic no_pulse();
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      `CHK("pulses", 2'h0, {upd, prf})
    end
  endtask

  // sweep: each field ramps by its delta from its landing cycle on
  task automatic watch(input int lf, input int lp, input int la,
                       input ddl_words_t o, input ddl_words_t d,
                       input bit swp);
    ddl_words_t e;
    for (int k = 1; k <= 45; k++) begin
      @(negedge clk_i);
      e = o;
      if (k >= lf) begin
        e.frq = swp ? o.frq + d.frq * `DDL_FRQ_W'(k - lf + 1) : d.frq;
      end
      if (k >= lp) begin
        e.phs = swp ? o.phs + d.phs * `DDL_PHS_W'(k - lp + 1) : d.phs;
      end
      if (k >= la) begin
        e.amp = swp ? o.amp + d.amp * `DDL_AMP_W'(k - la + 1) : d.amp;
      end
      `CHK("out_words", e, outw)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_unmatched();
    mode    = DDL_MODE_SINGLE;
    matched = 1'b0;
    cw      = WD_A;
    u_ctrl.strobe();
    wait_evt(1'b0);
    watch(29, 25, 17, 56'h0, WD_A, 1'b0);
    $display("single tone unmatched done");
  endtask

  task automatic t_matched();
    matched = 1'b1;
    cw      = WD_B;
    u_ctrl.strobe();
    wait_evt(1'b0);
    watch(29, 29, 29, WD_A, WD_B, 1'b0);
    $display("single tone matched done");
  endtask

  task automatic t_modulation();
    mode = DDL_MODE_MOD;
    pw   = WD_C;
    u_ctrl.strobe();
    no_pulse(); // commit ignored, profile unchanged
    u_ctrl.set_profile(4'h6);
    wait_evt(1'b1);
    watch(34, 29, 21, WD_B, WD_C, 1'b0);
    `CHK("profile_sel", 4'h6, sel)
    $display("modulation done");
  endtask

  task automatic t_sweep(input logic [`DDL_PROF_W-1:0] p);
    mode = DDL_MODE_SINGLE;
    do_reset(8);
    u_ctrl.set_profile(p);
    no_pulse(); // profile pins ignored in single tone
    mode = DDL_MODE_SWEEP;
    wait_evt(1'b1);
    watch(41, 37, 29, 56'h0, p[0] ? DL_UP : DL_DN, 1'b1);
    `CHK("profile_sel", p, sel)
    $display("sweep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i   = 1'b0;
    rst_i   = 1'b1;
    mode    = DDL_MODE_SINGLE;
    matched = 1'b0;
    cw      = '0;
    pw      = '0;
    rw      = DL_UP;
    fw      = DL_DN;
    errors  = 0;
    checks  = 0;
    do_reset(3);
    t_unmatched();
    t_matched();
    t_modulation();
    t_sweep(4'h1);
    t_sweep(4'h2);
    end_of_test();
  end

  // a run takes about 1.5 us; a hang is cut off well beyond that
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
